// ---- verilog/teom_pkg.sv ----
// Constants for the event / one-shot timer: register map, field positions,
// reset values and encodings. Assumes a 32-bit AXI4-Lite register bus.
package teom_pkg;
  localparam int unsigned TEOM_CNT_W = 16;
  localparam logic [TEOM_CNT_W-1:0] TEOM_ALL_ONES = 16'hFFFF;
  localparam logic [TEOM_CNT_W-1:0] TEOM_ZERO = 16'h0000;
  localparam logic [TEOM_CNT_W-1:0] TEOM_RELOAD_RST = 16'h0000;
  localparam logic [TEOM_CNT_W-1:0] TEOM_PRESCALE_RST = 16'h0000;

  // Register byte offsets.
  localparam logic [7:0] TEOM_OFF_CTRL = 8'h00;
  localparam logic [7:0] TEOM_OFF_EVT = 8'h04;
  localparam logic [7:0] TEOM_OFF_RELOAD = 8'h08;
  localparam logic [7:0] TEOM_OFF_COUNT = 8'h0C;
  localparam logic [7:0] TEOM_OFF_PRESCALE = 8'h10;

  // Control register fields.
  localparam int unsigned TEOM_CTRL_W = 7;
  localparam logic [TEOM_CTRL_W-1:0] TEOM_CTRL_RST = 7'h00;
  localparam int unsigned TEOM_B_ENABLE = 0;
  localparam int unsigned TEOM_B_RESET = 1;
  localparam int unsigned TEOM_B_DIR_UP = 2;
  localparam int unsigned TEOM_B_RELOAD_SEL = 3;
  localparam int unsigned TEOM_B_ONESHOT = 4;
  localparam int unsigned TEOM_B_EVENT = 5;
  localparam int unsigned TEOM_B_POUT_EN = 6;

  // Event control register fields.
  localparam int unsigned TEOM_EVT_W = 5;
  localparam logic [TEOM_EVT_W-1:0] TEOM_EVT_RST = 5'h00;
  localparam int unsigned TEOM_B_EDGE_RISE = 0;
  localparam int unsigned TEOM_B_EDGE_FALL = 1;
  localparam int unsigned TEOM_B_SRC_CHAIN = 2;
  localparam int unsigned TEOM_B_START_LO = 3;
  localparam int unsigned TEOM_B_START_HI = 4;
  localparam logic [1:0] TEOM_START_ENABLE = 2'h0;
  localparam logic [1:0] TEOM_START_CHAIN = 2'h1;
  localparam logic [1:0] TEOM_START_INPUT = 2'h2;

  localparam logic [1:0] TEOM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TEOM_RESP_DECERR = 2'h3;

  typedef enum logic {TEOM_OS_IDLE, TEOM_OS_RUN} teom_os_e;
endpackage

// ---- verilog/teom_timer.sv ----
// One 16-bit timer/counter with event mode and one-shot mode, AXI4-Lite slave.
// Assumes inputs are synchronous to aclk and the chained overflow input comes
// from the previous timer instance as a one-clock pulse.
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module teom_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_event_input,
  input wire logic chain_overflow_in,
  output logic timer_pulse_output,
  output logic chain_overflow_out,
  output logic irq_request
);

  logic [teom_pkg::TEOM_CTRL_W-1:0] ctrl;
  logic [teom_pkg::TEOM_EVT_W-1:0] evt_cfg;
  logic [teom_pkg::TEOM_CNT_W-1:0] reload;
  logic [teom_pkg::TEOM_CNT_W-1:0] prescale;
  logic [teom_pkg::TEOM_CNT_W-1:0] div_cnt;
  logic [teom_pkg::TEOM_CNT_W-1:0] count;
  logic in_q;
  logic chain_q;
  logic clr_pending;
  teom_pkg::teom_os_e os_state;
  teom_pkg::teom_os_e next_os_state;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus decode.
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire wr_ctrl = wr_go && (s_axi_awaddr == teom_pkg::TEOM_OFF_CTRL);
  wire wr_evt = wr_go && (s_axi_awaddr == teom_pkg::TEOM_OFF_EVT);
  wire wr_reload = wr_go && (s_axi_awaddr == teom_pkg::TEOM_OFF_RELOAD);
  wire wr_pre = wr_go && (s_axi_awaddr == teom_pkg::TEOM_OFF_PRESCALE);
  wire wr_hit = wr_ctrl || wr_evt || wr_reload || wr_pre ||
                (s_axi_awaddr == teom_pkg::TEOM_OFF_COUNT);
  wire [31:0] wval = s_axi_wdata & wmask;
  wire [31:0] ctrl_new = ({25'h000_0000, ctrl} & ~wmask) | wval;
  wire [31:0] evt_new = ({27'h000_0000, evt_cfg} & ~wmask) | wval;
  wire [31:0] reload_new = ({16'h0000, reload} & ~wmask) | wval;
  wire [31:0] pre_new = ({16'h0000, prescale} & ~wmask) | wval;

  // Reset control is a write-one strobe; it is never stored.
  wire rst_evt = wr_ctrl && ctrl_new[teom_pkg::TEOM_B_RESET];
  // The direction and mode written together with the strobe pick the start value.
  wire rst_up = ctrl_new[teom_pkg::TEOM_B_DIR_UP];
  wire rst_os = ctrl_new[teom_pkg::TEOM_B_ONESHOT];

  wire rd_ctrl = s_axi_araddr == teom_pkg::TEOM_OFF_CTRL;
  wire rd_evt = s_axi_araddr == teom_pkg::TEOM_OFF_EVT;
  wire rd_reload = s_axi_araddr == teom_pkg::TEOM_OFF_RELOAD;
  wire rd_count = s_axi_araddr == teom_pkg::TEOM_OFF_COUNT;
  wire rd_pre = s_axi_araddr == teom_pkg::TEOM_OFF_PRESCALE;
  wire rd_hit = rd_ctrl || rd_evt || rd_reload || rd_count || rd_pre;
  wire [31:0] rd_val = rd_ctrl ? {25'h000_0000, ctrl} :
                       rd_evt ? {27'h000_0000, evt_cfg} :
                       rd_reload ? {16'h0000, reload} :
                       rd_count ? {16'h0000, count} :
                       rd_pre ? {16'h0000, prescale} : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration fields and event detection.
  wire enable = ctrl[teom_pkg::TEOM_B_ENABLE];
  wire dir_up = ctrl[teom_pkg::TEOM_B_DIR_UP];
  wire reload_on_wrap_sel = ctrl[teom_pkg::TEOM_B_RELOAD_SEL];
  wire oneshot = ctrl[teom_pkg::TEOM_B_ONESHOT];
  wire event_mode = ctrl[teom_pkg::TEOM_B_EVENT];
  wire pout_en = ctrl[teom_pkg::TEOM_B_POUT_EN];
  wire [1:0] start_sel = evt_cfg[teom_pkg::TEOM_B_START_HI:teom_pkg::TEOM_B_START_LO];

  wire ev_src = evt_cfg[teom_pkg::TEOM_B_SRC_CHAIN] ? chain_overflow_in : timer_event_input;
  wire ev_prev = evt_cfg[teom_pkg::TEOM_B_SRC_CHAIN] ? chain_q : in_q;
  wire ev_hit = (evt_cfg[teom_pkg::TEOM_B_EDGE_RISE] && ev_src && !ev_prev) ||
                (evt_cfg[teom_pkg::TEOM_B_EDGE_FALL] && !ev_src && ev_prev);
  wire chain_rise = chain_overflow_in && !chain_q;
  wire in_edge = (evt_cfg[teom_pkg::TEOM_B_EDGE_RISE] && timer_event_input && !in_q) ||
                 (evt_cfg[teom_pkg::TEOM_B_EDGE_FALL] && !timer_event_input && in_q);

  // The prescaler stands in for the programmable timer clock.
  wire clk_tick = div_cnt == prescale;
  wire os_tick = event_mode ? chain_rise : clk_tick;

  wire start_cond = (start_sel == teom_pkg::TEOM_START_ENABLE) ||
                    ((start_sel == teom_pkg::TEOM_START_CHAIN) && chain_rise) ||
                    ((start_sel == teom_pkg::TEOM_START_INPUT) && in_edge);
  wire os_start = oneshot && enable && (os_state == teom_pkg::TEOM_OS_IDLE) &&
                  start_cond && !rst_evt;
  wire os_run = oneshot && (os_state == teom_pkg::TEOM_OS_RUN);
  wire os_under = os_run && os_tick && (count == teom_pkg::TEOM_ZERO) && !rst_evt;

  wire ev_step = !oneshot && enable && ev_hit && !rst_evt;
  wire ev_wrap = ev_step && (dir_up ? (count == teom_pkg::TEOM_ALL_ONES) :
                                      (count == teom_pkg::TEOM_ZERO));
  wire [15:0] wrap_val = reload_on_wrap_sel ? reload :
                         (dir_up ? teom_pkg::TEOM_ZERO : teom_pkg::TEOM_ALL_ONES);
  wire [15:0] step_val = dir_up ? count + 16'h0001 : count - 16'h0001;

  logic [teom_pkg::TEOM_CNT_W-1:0] next_count;
  always_comb
  begin
    next_count = count;
    next_os_state = os_state;
    if (rst_evt)
    begin
      next_count = (rst_os || !rst_up) ? reload : teom_pkg::TEOM_ZERO;
      next_os_state = teom_pkg::TEOM_OS_IDLE;
    end
    else if (os_start)
    begin
      next_count = reload;
      next_os_state = teom_pkg::TEOM_OS_RUN;
    end
    else if (os_under)
      next_os_state = teom_pkg::TEOM_OS_IDLE;
    else if (os_run && os_tick)
      next_count = count - 16'h0001;
    else if (!oneshot)
    begin
      next_os_state = teom_pkg::TEOM_OS_IDLE;
      if (ev_wrap)
        next_count = wrap_val;
      else if (ev_step)
        next_count = step_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= teom_pkg::TEOM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= teom_pkg::TEOM_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? teom_pkg::TEOM_RESP_OKAY : teom_pkg::TEOM_RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? teom_pkg::TEOM_RESP_OKAY : teom_pkg::TEOM_RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and timer state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= teom_pkg::TEOM_CTRL_RST;
      evt_cfg <= teom_pkg::TEOM_EVT_RST;
      reload <= teom_pkg::TEOM_RELOAD_RST;
      prescale <= teom_pkg::TEOM_PRESCALE_RST;
      div_cnt <= teom_pkg::TEOM_ZERO;
      count <= teom_pkg::TEOM_ZERO;
      in_q <= 1'b0;
      chain_q <= 1'b0;
      clr_pending <= 1'b0;
      os_state <= teom_pkg::TEOM_OS_IDLE;
    end
    else
    begin
      in_q <= timer_event_input;
      chain_q <= chain_overflow_in;
      div_cnt <= clk_tick ? teom_pkg::TEOM_ZERO : div_cnt + 16'h0001;
      count <= next_count;
      os_state <= next_os_state;
      // A software write wins over the hardware clear of enable.
      if (wr_ctrl)
        ctrl <= {ctrl_new[teom_pkg::TEOM_CTRL_W-1:teom_pkg::TEOM_B_RESET+1], 1'b0,
                 ctrl_new[teom_pkg::TEOM_B_ENABLE]};
      else if (clr_pending && os_tick)
        ctrl[teom_pkg::TEOM_B_ENABLE] <= 1'b0;
      if (os_start)
        clr_pending <= 1'b1;
      else if (os_tick || rst_evt)
        clr_pending <= 1'b0;
      if (wr_evt)
        evt_cfg <= evt_new[teom_pkg::TEOM_EVT_W-1:0];
      if (wr_reload)
        reload <= reload_new[15:0];
      if (wr_pre)
        prescale <= pre_new[15:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chain_overflow_out <= 1'b0;
      irq_request <= 1'b0;
      timer_pulse_output <= 1'b0;
    end
    else
    begin
      chain_overflow_out <= ev_wrap || os_under;
      irq_request <= ev_wrap || os_under;
      if (oneshot)
        timer_pulse_output <= os_start || (os_run && !os_under && !rst_evt);
      else if (!pout_en)
        timer_pulse_output <= 1'b0;
      else if (ev_wrap)
        timer_pulse_output <= !timer_pulse_output;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence s_shot_start;
    os_start;
  endsequence
  sequence s_shot_running;
    os_state == teom_pkg::TEOM_OS_RUN && timer_pulse_output && count == $past(reload);
  endsequence

  chk_wrap_toggles_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_wrap && pout_en |=> timer_pulse_output != $past(timer_pulse_output))
    else $error("pulse output did not toggle on wrap");
  chk_reset_down_load: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_evt && !rst_os && !rst_up |=> count == $past(reload))
    else $error("reset did not load reload value");
  chk_reset_up_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_evt && !rst_os && rst_up |=> count == teom_pkg::TEOM_ZERO)
    else $error("reset did not clear count when counting up");
  chk_hold_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    !oneshot && !enable && !rst_evt |=> $stable(count))
    else $error("count moved while disabled");
  chk_down_step: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_step && !dir_up && count != teom_pkg::TEOM_ZERO |=> count == $past(count) - 16'h0001)
    else $error("down count step wrong");
  chk_under_roll: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_wrap && !dir_up && !reload_on_wrap_sel |=> count == teom_pkg::TEOM_ALL_ONES && irq_request)
    else $error("underflow roll or interrupt wrong");
  chk_shot_start: assert property (@(posedge aclk) disable iff (!aresetn)
    s_shot_start |=> s_shot_running)
    else $error("one-shot start state wrong");
  chk_shot_end: assert property (@(posedge aclk) disable iff (!aresetn)
    os_under |=> os_state == teom_pkg::TEOM_OS_IDLE && !timer_pulse_output && irq_request
    ##1 !irq_request)
    else $error("one-shot end wrong");
  chk_no_start_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    oneshot && !enable && os_state == teom_pkg::TEOM_OS_IDLE
    |=> os_state == teom_pkg::TEOM_OS_IDLE)
    else $error("one-shot started while disabled");
  chk_enable_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_pending && os_tick && !wr_ctrl |=> !enable)
    else $error("enable not cleared after start tick");

endmodule

// ---- sim/teom_partner.sv ----
// Far side of the timer: the external event pin and the previous timer.
// Assumes one-cycle request strobes from the bench, synchronous to aclk.
`timescale 1ns/10ps
module teom_partner
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic toggle_req,
  input wire logic chain_req,
  output logic timer_event_input,
  output logic chain_overflow_in
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_event_input <= 1'b0;
      chain_overflow_in <= 1'b0;
    end
    else
    begin
      timer_event_input <= timer_event_input ^ toggle_req;
      chain_overflow_in <= chain_req;
    end
  end
endmodule

// ---- sim/test_timer_event_oneshot_modes.sv ----
// Self-checking bench for the event / one-shot timer over AXI4-Lite.
// Assumes the partner model drives the event pin and the chained overflow.
`timescale 1ns/10ps
module test_timer_event_oneshot_modes;
  localparam logic [31:0] CEN = 32'h0000_0001;
  localparam logic [31:0] CRST = 32'h0000_0002;
  localparam logic [31:0] CUP = 32'h0000_0004;
  localparam logic [31:0] CSEL = 32'h0000_0008;
  localparam logic [31:0] COS = 32'h0000_0010;
  localparam logic [31:0] CEV = 32'h0000_0020;
  localparam logic [31:0] CPO = 32'h0000_0040;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_wvalid = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic tog = 1'b0;
  logic chn = 1'b0;
  logic ev_in, ch_in, pout, pout_q, ch_out, irq;
  int error_cnt = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int rise_cnt = 0;
  int ch_cnt = 0;
  int cnt, rl, irq_exp, lvl, edg;
  bit up, sel, en, pout_exp;
  logic [31:0] d;
  logic [1:0] r;
  int cfg[4] = '{1, 2, 3, 5};

  always #20 aclk = !aclk;

  teom_partner i_far (.aclk(aclk), .aresetn(aresetn), .toggle_req(tog), .chain_req(chn),
    .timer_event_input(ev_in), .chain_overflow_in(ch_in));

  teom_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .timer_event_input(ev_in), .chain_overflow_in(ch_in),
    .timer_pulse_output(pout), .chain_overflow_out(ch_out), .irq_request(irq));

  always @(posedge aclk)
  begin
    pout_q <= pout;
    if (irq === 1'b1)
      irq_cnt++;
    if (ch_out === 1'b1)
      ch_cnt++;
    if (pout === 1'b1 && pout_q === 1'b0)
      rise_cnt++;
  end

  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  // Each channel is released at the edge where its own ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw_done = 1'b0;
    bit w_done = 1'b0;
    bit b_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done && b_done))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_done)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_done)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1 && !b_done)
      begin
        b_done = 1'b1;
        r = s_axi_bresp;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bit ar_done = 1'b0;
    bit r_done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!(ar_done && r_done))
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1 && !ar_done)
      begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1 && !r_done)
      begin
        r_done = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, d);
  endtask

  // Reference counter: one qualified edge moves it one step or wraps it.
  task automatic model_evt(input bit rise);
    if (en && edg[rise ? 0 : 1])
    begin
      if (up ? cnt == 65535 : cnt == 0)
      begin
        cnt = sel ? rl : (up ? 0 : 65535);
        irq_exp++;
        pout_exp = !pout_exp;
      end
      else
        cnt = up ? cnt + 1 : cnt - 1;
    end
  endtask

  task automatic fire(input bit chain);
    @(posedge aclk);
    if (chain)
      chn <= 1'b1;
    else
      tog <= 1'b1;
    @(posedge aclk);
    chn <= 1'b0;
    tog <= 1'b0;
    repeat (4) @(posedge aclk);
    lvl = chain ? lvl : !lvl;
    model_evt(chain ? 1'b1 : lvl[0]);
    if (chain)
      model_evt(1'b0);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    en = v[0];
    up = v[2];
    sel = v[3];
    if (v[1])
      cnt = up ? 0 : rl;
    wr(teom_pkg::TEOM_OFF_CTRL, v);
  endtask

  task automatic ev_step(input bit chain);
    fire(chain);
    rc("count", teom_pkg::TEOM_OFF_COUNT, cnt);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    void'($urandom(63));
    lvl = 0;
    irq_exp = 0;
    pout_exp = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", teom_pkg::TEOM_OFF_CTRL, 32'h0000_0000);
    rc("count", teom_pkg::TEOM_OFF_COUNT, 32'h0000_0000);
    rd(8'h40);
    chk("resp", 32'(teom_pkg::TEOM_RESP_DECERR), 32'(r));
    wr(8'h40, 32'h0000_0001);
    chk("bresp", 32'(teom_pkg::TEOM_RESP_DECERR), 32'(r));
    rl = $urandom_range(6, 2);
    wr(teom_pkg::TEOM_OFF_RELOAD, rl);
    for (int k = 0; k < 4; k++)
    begin
      edg = cfg[k];
      wr(teom_pkg::TEOM_OFF_EVT, edg);
      set_ctrl(CEV | CSEL | CPO | CRST);
      rc("count", teom_pkg::TEOM_OFF_COUNT, cnt);
      set_ctrl(CEV | CSEL | CPO | CEN);
      repeat (rl + 2) ev_step(edg[2]);
      chk("irq", irq_exp, irq_cnt);
      chk("pulse", pout_exp, pout);
    end
    edg = 3;
    wr(teom_pkg::TEOM_OFF_EVT, edg);
    set_ctrl(CEV | CSEL);
    repeat (2) ev_step(0);
    set_ctrl(CEV | CSEL | CEN);
    repeat (2) ev_step(0);
    set_ctrl(CEV | CUP | CRST);
    rc("count", teom_pkg::TEOM_OFF_COUNT, cnt);
    set_ctrl(CEV | CUP | CEN);
    repeat (2) ev_step(0);
    set_ctrl(CEV | CEN);
    repeat (3) ev_step(0);
    chk("irq", irq_exp, irq_cnt);
    set_ctrl(32'h0000_0000);
    repeat (4) @(posedge aclk);
    rise_cnt = 0;
    for (int m = 0; m < 3; m++)
    begin
      edg = 1;
      wr(teom_pkg::TEOM_OFF_EVT, (m << 3) | 1);
      wr(teom_pkg::TEOM_OFF_CTRL, COS | CPO);
      if (m > 0)
        repeat (2) fire(m == 1);
      chk("irq", irq_exp, irq_cnt);
      wr(teom_pkg::TEOM_OFF_CTRL, COS | CPO | CEN);
      if (m > 0)
        repeat (2) fire(m == 1);
      repeat (rl + 12) @(posedge aclk);
      irq_exp++;
      chk("irq", irq_exp, irq_cnt);
      chk("rises", m + 1, rise_cnt);
      chk("pulse", 0, pout);
      rc("ctrl", teom_pkg::TEOM_OFF_CTRL, COS | CPO);
      rc("count", teom_pkg::TEOM_OFF_COUNT, 32'h0000_0000);
    end
    // One-shot in event mode: each chained rise is one tick.
    wr(teom_pkg::TEOM_OFF_EVT, 32'h0000_0001);
    wr(teom_pkg::TEOM_OFF_CTRL, COS | CEV | CEN);
    fire(1);
    rc("count", teom_pkg::TEOM_OFF_COUNT, rl - 1);
    rc("ctrl", teom_pkg::TEOM_OFF_CTRL, COS | CEV);
    repeat (rl) fire(1);
    irq_exp++;
    chk("irq", irq_exp, irq_cnt);
    chk("chain", irq_exp, ch_cnt);
    stop_test();
  end
endmodule
